//--- hdl/dram_refresh_controller_defines.vh
// Constants for the dynamic RAM controller: states, timing counts and reset values.
`ifndef DRAM_REFRESH_CONTROLLER_DEFINES_VH
`define DRAM_REFRESH_CONTROLLER_DEFINES_VH

// =====================================================================
// Controller states
`define ST_IDLE          3'h0
`define ST_TEST          3'h1
`define ST_REFRESH       3'h2
`define ST_READ          3'h3
`define ST_WRITE         3'h4

// =====================================================================
// Cycle phases, counted in clock cycles from the start of a cycle
`define PH_ROW_STROBE    4'h1
`define PH_COL_ADDR      4'h2
`define PH_WRITE_STROBE  4'h2
`define PH_COL_STROBE    4'h3
`define PH_XFER_ACK      4'h5
`define PH_REFRESH_END   4'h5
`define PH_CYCLE_END     4'h7

// =====================================================================
// Refresh interval: 12 us, inside the documented 10 to 16 us window
`define REFRESH_INTERVAL_NS  12000
`define CLOCK_PERIOD_NS      10
`define REFRESH_CYCLES       (`REFRESH_INTERVAL_NS / `CLOCK_PERIOD_NS)
`define REFRESH_TIMER_W      11

// =====================================================================
// Reset values
`define REFRESH_ROW_RESET    8'h00
`define RAM_ADDR_IDLE        8'hFF
`define ROW_STROBES_IDLE     4'hF

`endif

//--- hdl/request_synchronizer.v
// Two-stage synchronizer for one asynchronous request level.
`timescale 1ns/1ns
`default_nettype none

module request_synchronizer (
   input  wire mclk_in,
   input  wire reset_n_in,
   input  wire async_in,
   output reg  sync_out
);

   reg meta_q;

   // =====================================================================
   // Only the second stage is seen by the rest of the block.
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // request_synchronizer

`default_nettype wire

//--- hdl/dram_refresh_controller.v
// Dynamic RAM controller with access/refresh arbitration and refresh timer.
// Operation
// - In 16K mode the advanced-read strap turns read input into status and refresh input into strobe.
// - Any external refresh request restarts the refresh interval timer.
// - Eight-bit refresh row counter advances after every completed refresh.
// - In 16K mode two bank bits pick one of four row strobes.
// - In 64K mode one bank bit picks one of two row strobes.
// - Access cycles drive row address first, then column address.
// - Refresh drives the row counter out; column strobe stays inactive.
// - RAM address outputs are the inverse of the selected source.
// - Asynchronous read, write and refresh requests are synchronized before arbitration.
// - At idle, pending reads and writes win over pending refresh.
// - Five states; rest in idle, return there when nothing pends.
// - Select, read and write together run a test: clear counter, then write.
// - Refresh asserts all row strobes; other strobes and acks stay inactive.
// - Without external requests the timer asks for refresh every 10-16 us.
// - External refresh requests are synchronized, then latched.
// - No external refresh while advanced read is selected.
// - Refresh starts only when no other cycle is running.
// - From idle, simultaneous access and refresh: access first, then refresh.
// - Outside idle, a simultaneous pair may be served refresh first.
// - Advanced read starts on the strobe's falling edge while status is high.
// - Read asked during refresh delays system ack to transfer ack; cleared per read.
// - All outputs change on the reference clock edge.
`timescale 1ns/1ns
`default_nettype none
`include "dram_refresh_controller_defines.vh"

module dram_refresh_controller (
   input  wire       mclk_in,
   input  wire       reset_n_in,
   input  wire       density_mode_select_in,
   input  wire       advanced_read_strap_in,
   input  wire       external_clock_strap_in,
   input  wire       protected_select_n_in,
   input  wire       mem_read_req_n_in,
   input  wire       mem_write_req_n_in,
   input  wire       ext_refresh_req_in,
   input  wire       bank_sel_0_in,
   input  wire       bank_sel_1_in,
   input  wire [7:0] row_addr_in,
   input  wire [7:0] col_addr_in,
   output reg  [7:0] ram_addr_out_n,
   output reg  [3:0] row_strobe_n_out,
   output reg        col_strobe_n_out,
   output reg        write_strobe_n_out,
   output reg        system_ack_n_out,
   output reg        transfer_ack_n_out,
   output reg  [7:0] refresh_row_out
);

   localparam integer REFRESH_LAST_FULL = `REFRESH_CYCLES - 1;
   // The interval count fits the timer width, so the cut below drops only zeros.
   localparam [`REFRESH_TIMER_W-1:0] REFRESH_LAST =
      REFRESH_LAST_FULL[`REFRESH_TIMER_W-1:0];

   reg [2:0]  state_q;
   reg [2:0]  state_d;
   reg [3:0]  phase_q;
   reg [7:0]  refresh_row_q;
   reg [`REFRESH_TIMER_W-1:0] timer_q;
   reg        timer_req_q;
   reg        ext_latch_q;
   reg        delayed_ack_q;
   reg        access_hold_q;
   reg        strobe_sync_last_q;
   reg [3:0]  bank_strobes;

   wire       read_raw;
   wire       ale_raw;
   wire       read_sync;
   wire       write_sync;
   wire       ale_sync;
   wire       ext_ref_sync;
   wire       adv_mode;
   wire       sel;
   wire       read_req;
   wire       write_req;
   wire       test_req;
   wire       access_req;
   wire       ext_seen;
   wire       refresh_req;
   wire       cycle_done;
   wire       ale_fall;

   // =====================================================================
   // Option decode and request synchronizers
   // The strap is honoured only in 16K mode; in 64K mode it has no effect.
   assign adv_mode = advanced_read_strap_in & density_mode_select_in;
   assign sel      = ~protected_select_n_in;
   // Both straps are static; external_clock_strap_in has no effect because the
   // block always runs from mclk_in.

   // Advanced read: read pin carries status, refresh pin carries the strobe.
   assign read_raw = adv_mode ? 1'b0 : ~mem_read_req_n_in;
   assign ale_raw  = adv_mode ? (ext_refresh_req_in & mem_read_req_n_in) : 1'b0;

   request_synchronizer u_sync_read (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .async_in   (read_raw),
      .sync_out   (read_sync)
   );

   request_synchronizer u_sync_write (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .async_in   (~mem_write_req_n_in),
      .sync_out   (write_sync)
   );

   request_synchronizer u_sync_ale (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .async_in   (ale_raw),
      .sync_out   (ale_sync)
   );

   // The raw refresh pin is synchronized first, then held in ext_latch_q until the refresh ends.
   request_synchronizer u_sync_ref (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .async_in   (ext_refresh_req_in & ~adv_mode),
      .sync_out   (ext_ref_sync)
   );

   // =====================================================================
   // Request qualification
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         strobe_sync_last_q <= 1'b0;
      end else begin
         strobe_sync_last_q <= ale_sync;
      end
   end

   assign ale_fall   = strobe_sync_last_q & ~ale_sync;
   // A held level request is served once; it must drop before it starts another cycle.
   assign read_req   = sel & ((read_sync & ~access_hold_q) | ale_fall);
   assign write_req  = sel & write_sync & ~access_hold_q;
   assign test_req   = sel & read_sync & write_sync & ~access_hold_q;
   assign access_req = read_req | write_req;
   assign ext_seen   = ext_ref_sync | ext_latch_q;
   assign refresh_req = ext_seen | timer_req_q;
   assign cycle_done = (state_q == `ST_REFRESH) ? (phase_q == `PH_REFRESH_END)
                                                : (phase_q == `PH_CYCLE_END);

   // =====================================================================
   // Bank decode
   // The decode is combinational from the pins; bank selects are not latched,
   // so the system must keep them stable for the whole cycle.
   function [3:0] bank_decode;
      input mode16;
      input b1;
      input b0;
      begin
         if (mode16) begin
            bank_decode = ~(4'h1 << {b1, b0});
         end else begin
            bank_decode = b0 ? 4'hD : 4'hE;
         end
      end
   endfunction

   always @* begin
      bank_strobes = bank_decode(density_mode_select_in, bank_sel_1_in, bank_sel_0_in);
   end

   // =====================================================================
   // State machine
   always @* begin
      state_d = state_q;
      case (state_q)
         `ST_IDLE: begin
            // Access beats refresh when both arrive together at idle.
            if (test_req) begin
               state_d = `ST_TEST;
            end else if (write_req) begin
               state_d = `ST_WRITE;
            end else if (read_req) begin
               state_d = `ST_READ;
            end else if (refresh_req) begin
               state_d = `ST_REFRESH;
            end
         end
         `ST_TEST, `ST_READ, `ST_WRITE, `ST_REFRESH: begin
            // A refresh latched during an access runs straight after it,
            // so an access held asserted cannot starve refresh.
            if (cycle_done) begin
               if (state_q != `ST_REFRESH && refresh_req) begin
                  state_d = `ST_REFRESH;
               end else begin
                  state_d = `ST_IDLE;
               end
            end
         end
         default: begin
            state_d = `ST_IDLE;
         end
      endcase
   end

   // Phase counts clock edges since the state was entered; idle does not count.
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= `ST_IDLE;
         phase_q <= 4'h0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            phase_q <= 4'h0;
         end else if (state_q != `ST_IDLE) begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   // =====================================================================
   // Refresh timer, external latch and row counter
   // The timer runs on every edge; an external request restarts it, so a system
   // that refreshes often enough never sees an internal refresh.
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         timer_q       <= {`REFRESH_TIMER_W{1'b0}};
         timer_req_q   <= 1'b0;
         ext_latch_q   <= 1'b0;
         refresh_row_q <= `REFRESH_ROW_RESET;
      end else begin
         if (ext_ref_sync) begin
            timer_q <= {`REFRESH_TIMER_W{1'b0}};
         end else if (timer_q == REFRESH_LAST) begin
            timer_q <= {`REFRESH_TIMER_W{1'b0}};
         end else begin
            timer_q <= timer_q + 1'b1;
         end
         // New requests win over the clear at the end of a refresh.
         if (!ext_ref_sync && timer_q == REFRESH_LAST) begin
            timer_req_q <= 1'b1;
         end else if (state_q == `ST_REFRESH && cycle_done) begin
            timer_req_q <= 1'b0;
         end
         if (ext_ref_sync) begin
            ext_latch_q <= 1'b1;
         end else if (state_q == `ST_REFRESH && cycle_done) begin
            ext_latch_q <= 1'b0;
         end
         if (state_q == `ST_TEST && phase_q == 4'h0) begin
            refresh_row_q <= `REFRESH_ROW_RESET;
         end else if (state_q == `ST_REFRESH && cycle_done) begin
            refresh_row_q <= refresh_row_q + 8'h01;
         end
      end
   end

   // =====================================================================
   // Delayed system acknowledge flag
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         delayed_ack_q <= 1'b0;
      end else if (state_q == `ST_REFRESH && read_req) begin
         delayed_ack_q <= 1'b1;
      end else if (state_q == `ST_READ && cycle_done) begin
         delayed_ack_q <= 1'b0;
      end
   end

   // =====================================================================
   // Served-request hold
   // The request synchronizers lag the pins by two edges, so a read released on
   // the transfer acknowledge still looks active when the cycle ends. Without
   // this hold that stale level would start a second, unwanted cycle.
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         access_hold_q <= 1'b0;
      end else if (state_q != `ST_IDLE && state_q != `ST_REFRESH && cycle_done) begin
         access_hold_q <= 1'b1;
      end else if (!read_sync && !write_sync) begin
         access_hold_q <= 1'b0;
      end
   end

   // =====================================================================
   // RAM-side and processor-side outputs, all registered
   // Every output comes from a flip-flop, so the pins lag the phase counter by one edge.
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ram_addr_out_n     <= `RAM_ADDR_IDLE;
         row_strobe_n_out   <= `ROW_STROBES_IDLE;
         col_strobe_n_out   <= 1'b1;
         write_strobe_n_out <= 1'b1;
         system_ack_n_out   <= 1'b1;
         transfer_ack_n_out <= 1'b1;
         refresh_row_out    <= `REFRESH_ROW_RESET;
      end else begin
         refresh_row_out    <= refresh_row_q;
         row_strobe_n_out   <= `ROW_STROBES_IDLE;
         col_strobe_n_out   <= 1'b1;
         write_strobe_n_out <= 1'b1;
         system_ack_n_out   <= 1'b1;
         transfer_ack_n_out <= 1'b1;
         ram_addr_out_n     <= ~row_addr_in;
         case (state_q)
            `ST_REFRESH: begin
               ram_addr_out_n <= ~refresh_row_q;
               if (phase_q >= `PH_ROW_STROBE && !cycle_done) begin
                  row_strobe_n_out <= 4'h0;
               end
            end
            `ST_READ, `ST_WRITE, `ST_TEST: begin
               if (phase_q >= `PH_COL_ADDR) begin
                  ram_addr_out_n <= ~col_addr_in;
               end
               if (phase_q >= `PH_ROW_STROBE && !cycle_done) begin
                  row_strobe_n_out <= bank_strobes;
               end
               if (phase_q >= `PH_COL_STROBE && !cycle_done) begin
                  col_strobe_n_out <= 1'b0;
               end
               // Early write: the write strobe leads the column strobe.
               if (state_q != `ST_READ && phase_q >= `PH_WRITE_STROBE && !cycle_done) begin
                  write_strobe_n_out <= 1'b0;
               end
               if (phase_q == `PH_XFER_ACK || phase_q == `PH_XFER_ACK + 4'h1) begin
                  transfer_ack_n_out <= 1'b0;
               end
               if (state_q == `ST_READ && delayed_ack_q) begin
                  if (phase_q >= `PH_XFER_ACK && !cycle_done) begin
                     system_ack_n_out <= 1'b0;
                  end
               end else if (phase_q >= `PH_ROW_STROBE && !cycle_done) begin
                  system_ack_n_out <= 1'b0;
               end
            end
            default: begin
               ram_addr_out_n <= ~row_addr_in;
            end
         endcase
      end
   end

endmodule // dram_refresh_controller

`default_nettype wire

//--- verif/dram_refresh_controller_properties.sv
// Port-level assertions for the dynamic RAM controller.
`timescale 1ns/1ns
`default_nettype none
module dram_refresh_controller_properties (
   input wire       mclk_in,
   input wire       reset_n_in,
   input wire       density_mode_select_in,
   input wire       bank_sel_0_in,
   input wire       bank_sel_1_in,
   input wire [7:0] row_addr_in,
   input wire [7:0] col_addr_in,
   input wire [7:0] ram_addr_out_n,
   input wire [3:0] row_strobe_n_out,
   input wire       col_strobe_n_out,
   input wire       write_strobe_n_out,
   input wire       system_ack_n_out,
   input wire       transfer_ack_n_out,
   input wire [7:0] refresh_row_out
);
   // An access never lowers two row strobes, so two low strobes mean refresh in either mode.
   wire       refr = !row_strobe_n_out[0] && !row_strobe_n_out[1];
   reg [10:0] gap_q;
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) gap_q <= 11'h000;
      else if (refr) gap_q <= 11'h000;
      else if (gap_q != 11'h7ff) gap_q <= gap_q + 11'h001;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   chk_refresh_quiet: assert property (refr |-> col_strobe_n_out && write_strobe_n_out
      && system_ack_n_out && transfer_ack_n_out) else $error("refresh drove a strobe or ack");
   chk_refresh_addr: assert property (refr && !$past(refr)
      |-> ram_addr_out_n == ~refresh_row_out) else $error("refresh address wrong");
   chk_bank_four: assert property (!col_strobe_n_out && density_mode_select_in
      |-> row_strobe_n_out == (4'hf ^ (4'h1 << {bank_sel_1_in, bank_sel_0_in})))
      else $error("four-bank strobe wrong");
   chk_bank_two: assert property (!col_strobe_n_out && !density_mode_select_in
      |-> row_strobe_n_out == (bank_sel_0_in ? 4'hd : 4'he)) else $error("two-bank strobe wrong");
   chk_row_addr: assert property ($fell(&row_strobe_n_out) && !refr
      |-> ram_addr_out_n == ~row_addr_in) else $error("row address wrong");
   chk_col_addr: assert property ($fell(col_strobe_n_out)
      |-> ram_addr_out_n == ~col_addr_in) else $error("column address wrong");
   chk_transfer_ack_n_pulse: assert property ($fell(transfer_ack_n_out)
      |-> !system_ack_n_out ##1 !transfer_ack_n_out ##1 transfer_ack_n_out)
      else $error("transfer ack pulse wrong");
   chk_counter_step: assert property ($changed(refresh_row_out)
      |-> refresh_row_out == $past(refresh_row_out) + 8'h01 || refresh_row_out == 8'h00)
      else $error("refresh counter jumped");
   chk_timer_bound: assert property (gap_q < 11'h668) else $error("refresh overdue");
   cover property (refr);
   cover property ($fell(transfer_ack_n_out) && !write_strobe_n_out);
   cover property ($fell(transfer_ack_n_out) && write_strobe_n_out);
endmodule // dram_refresh_controller_properties
bind dram_refresh_controller dram_refresh_controller_properties i_props (.mclk_in, .reset_n_in,
   .density_mode_select_in, .bank_sel_0_in, .bank_sel_1_in, .row_addr_in, .col_addr_in,
   .ram_addr_out_n, .row_strobe_n_out, .col_strobe_n_out, .write_strobe_n_out,
   .system_ack_n_out, .transfer_ack_n_out, .refresh_row_out);
`default_nettype wire

//--- verif/dram_array_model.sv
// Behavioural RAM array that records the addresses it is strobed with.
`timescale 1ns/1ns
`default_nettype none
module dram_array_model (
   input  wire        mclk_in,
   input  wire  [7:0] ram_addr_n_in,
   input  wire  [3:0] row_strobe_n_in,
   input  wire        col_strobe_n_in,
   input  wire        write_strobe_n_in,
   output logic [7:0] row_out = 8'h00,
   output logic [7:0] col_out = 8'h00,
   output logic [3:0] bank_out = 4'hf,
   output logic       wr_out = 1'b0,
   output logic [7:0] ref_addr_out = 8'h00,
   output logic [7:0] ref_cnt_out = 8'h00,
   output logic [7:0] acc_cnt_out = 8'h00
);
   logic [3:0] rs_q = 4'hf;
   logic       cs_q = 1'b1;
   always @(posedge mclk_in) begin
      rs_q <= row_strobe_n_in;
      cs_q <= col_strobe_n_in;
      if (rs_q == 4'hf && row_strobe_n_in != 4'hf) begin
         if (row_strobe_n_in[1:0] == 2'b00) begin
            ref_addr_out <= ~ram_addr_n_in;
            ref_cnt_out <= ref_cnt_out + 8'h01;
         end else begin
            row_out <= ~ram_addr_n_in;
            bank_out <= row_strobe_n_in;
         end
      end
      // Early write: the write strobe is already low when the column strobe falls.
      if (cs_q && !col_strobe_n_in) begin
         col_out <= ~ram_addr_n_in;
         wr_out <= !write_strobe_n_in;
         acc_cnt_out <= acc_cnt_out + 8'h01;
      end
   end
endmodule // dram_array_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking testbench for the dynamic RAM controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic       mclk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       dens = 1'b1, adv = 1'b0, pcs_n = 1'b0, rd_n = 1'b1, wr_n = 1'b1, ext = 1'b0;
   logic       b0 = 1'b0, b1 = 1'b0;
   logic [7:0] row = 8'h00, col = 8'h00, c, a;
   wire  [7:0] addr_n, rrow, m_row, m_col, m_radr, m_rcnt, m_acnt;
   wire  [3:0] rs_n, m_bank;
   wire        cs_n, we_n, system_ack_n_n, transfer_ack_n_n, m_wr;
   int         error_cnt = 0, n_checks = 0, cyc = 0, k;
   dram_refresh_controller i_dram_refresh_controller (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .density_mode_select_in(dens), .advanced_read_strap_in(adv), .external_clock_strap_in(1'b0),
      .protected_select_n_in(pcs_n), .mem_read_req_n_in(rd_n), .mem_write_req_n_in(wr_n),
      .ext_refresh_req_in(ext), .bank_sel_0_in(b0), .bank_sel_1_in(b1), .row_addr_in(row),
      .col_addr_in(col), .ram_addr_out_n(addr_n), .row_strobe_n_out(rs_n),
      .col_strobe_n_out(cs_n), .write_strobe_n_out(we_n), .system_ack_n_out(system_ack_n_n),
      .transfer_ack_n_out(transfer_ack_n_n), .refresh_row_out(rrow));
   dram_array_model i_dram_array_model (.mclk_in(mclk_in), .ram_addr_n_in(addr_n),
      .row_strobe_n_in(rs_n), .col_strobe_n_in(cs_n), .write_strobe_n_in(we_n), .row_out(m_row),
      .col_out(m_col), .bank_out(m_bank), .wr_out(m_wr), .ref_addr_out(m_radr),
      .ref_cnt_out(m_rcnt), .acc_cnt_out(m_acnt));
   always #5 mclk_in = ~mclk_in;
   // ==========================================================
   // Tasks
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt = error_cnt + 1;
         complete_run;
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_ref(input logic [7:0] c0, input int lim, input logic [7:0] e);
      for (int i = 0; i < lim && m_rcnt == c0; i++) @(posedge mclk_in);
      chk("refresh count", e, m_rcnt);
   endtask
   // Kinds: 0 read, 1 write, 2 test, 3 advanced read; e_system_ack_n is system ack lead over transfer ack.
   task automatic access(input int k, input logic [1:0] bk, input logic [7:0] e_system_ack_n);
      logic [7:0] n, a0;
      n = 8'h00;
      a0 = m_acnt;
      {b1, b0} <= bk;
      row <= 8'hc3 ^ {6'h00, bk};
      col <= 8'h3c ^ {bk, 6'h00};
      rd_n <= (k == 1 || k == 3);
      wr_n <= !(k == 1 || k == 2);
      if (k == 3) ext <= 1'b1;
      for (int i = 0; i < 40 && transfer_ack_n_n !== 1'b0; i++) begin
         @(posedge mclk_in);
         ext <= 1'b0;
         if (system_ack_n_n === 1'b0 && transfer_ack_n_n !== 1'b0) n++;
      end
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      for (int i = 0; i < 20 && rs_n !== 4'hf; i++) @(posedge mclk_in);
      chk("sys ack lead", e_system_ack_n, n);
      chk("access count", a0 + 8'h01, m_acnt);
      chk("row addr", row, m_row);
      chk("col addr", col, m_col);
      chk("write", {7'h00, k == 1 || k == 2}, {7'h00, m_wr});
      if (k != 3) chk("bank", {4'h0, dens ? 4'hf ^ (4'h1 << bk) : (bk[0] ? 4'hd : 4'he)},
         {4'h0, m_bank});
      @(posedge mclk_in);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      @(posedge mclk_in);
      for (k = 0; k < 4; k++) access(0, k[1:0], 8'h04);
      dens <= 1'b0;
      for (k = 0; k < 2; k++) access(1, k[1:0], 8'h04);
      dens <= 1'b1;
      c = m_rcnt;
      ext <= 1'b1;
      access(0, 2'b01, 8'h04);
      chk("refresh deferred", c, m_rcnt);
      wait_ref(c, 10, c + 8'h01);
      c = m_rcnt;
      ext <= 1'b1;
      @(posedge mclk_in);
      ext <= 1'b0;
      for (int i = 0; i < 20 && rs_n !== 4'h0; i++) @(posedge mclk_in);
      access(0, 2'b10, 8'h00);
      chk("refresh count", c + 8'h01, m_rcnt);
      access(0, 2'b11, 8'h04);
      // A test cycle is issued only here, never amid normal traffic.
      access(2, 2'b00, 8'h04);
      chk("row counter", 8'h00, rrow);
      c = m_rcnt;
      wait_ref(c, 1700, c + 8'h01);
      chk("refresh addr", 8'h00, m_radr);
      repeat (8) @(posedge mclk_in);
      chk("row counter", 8'h01, rrow);
      repeat (600) @(posedge mclk_in);
      c = m_rcnt;
      ext <= 1'b1;
      @(posedge mclk_in);
      ext <= 1'b0;
      wait_ref(c, 10, c + 8'h01);
      chk("refresh addr", 8'h01, m_radr);
      c = m_rcnt;
      repeat (1000) @(posedge mclk_in);
      chk("timer restarted", c, m_rcnt);
      wait_ref(c, 700, c + 8'h01);
      adv <= 1'b1;
      rd_n <= 1'b0;
      @(posedge mclk_in);
      c = m_rcnt;
      a = m_acnt;
      ext <= 1'b1;
      @(posedge mclk_in);
      ext <= 1'b0;
      repeat (30) @(posedge mclk_in);
      chk("ignored strobe", a, m_acnt);
      chk("no ext refresh", c, m_rcnt);
      access(3, 2'b10, 8'h04);
      complete_run;
   end
endmodule // testbench
`default_nettype wire
